// [design/cgc_absence.sv]
/*
 Oscillator absence detector: flags the oscillator missing when no edge
 has been seen for a set number of register clocks, clears on any edge.
 Assumes edge pulses already aligned to the register clock.
*/
`timescale 1ns/1ps
module cgc_absence import cgc_pkg::*; #(
	parameter int unsigned ABS_CYC = ABSENT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Edge in, flag out
	input wire logic osc_edge,
	output logic absent
);
	typedef struct packed {
		logic [15:0] cnt;
		logic absent;
	} cgc_abs_st_t;

	cgc_abs_st_t st, nxt;

	always_comb begin
		nxt = st;
		if (osc_edge) begin
			nxt.cnt = 16'h0000;
			nxt.absent = 1'b0;
		end else if (st.cnt == 16'(ABS_CYC - 1)) begin
			nxt.absent = 1'b1;
		end else begin
			nxt.cnt = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	assign absent = st.absent;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_edge_clears: assert property (osc_edge |=> !st.absent)
		else $error("absence flag survived an oscillator edge");
endmodule // cgc_absence

// [design/cgc_ring.sv]
/*
 On-chip ring oscillator stand-in: a free running divider of the register
 clock giving a level and a one-cycle pulse at each rising transition.
 Assumes nothing of its surroundings but clock and reset.
*/
`timescale 1ns/1ps
module cgc_ring import cgc_pkg::*; #(
	parameter int unsigned HALF_CYC = RING_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Ring outputs
	output logic lvl,
	output logic rise
);
	typedef struct packed {
		logic [7:0] cnt;
		logic lvl;
		logic rise;
	} cgc_ring_st_t;

	cgc_ring_st_t st, nxt;

	always_comb begin
		nxt = st;
		nxt.rise = 1'b0;
		if (st.cnt == 8'(HALF_CYC - 1)) begin
			nxt.cnt = 8'h00;
			nxt.lvl = ~st.lvl;
			nxt.rise = ~st.lvl;
		end else begin
			nxt.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	assign lvl = st.lvl;
	assign rise = st.rise;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_ring_period: assert property ($rose(st.lvl) |=> st.lvl)
		else $error("ring high phase shorter than expected");
endmodule // cgc_ring

// [design/cgc_top.sv]
/*
 Clock generation and selection: halves the oscillator into the internal
 clock, drives mirror, system and delayed clocks, aligns to a reference
 clock, and falls back to the ring oscillator. AXI4-Lite control.
 Assumes all pins are synchronous to CLOCK and sampled at its rate.
*/
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module cgc_top import cgc_pkg::*; #(
	parameter int unsigned ABS_CYC = ABSENT_CYC,
	parameter int unsigned HALF_CYC = RING_HALF_CYC
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// Oscillator and system pins
	input wire logic OSC_IN_H,
	input wire logic OSC_IN_L,
	input wire logic SUPPLY_GOOD,
	input wire logic REF_CLK_IN,
	// Clock outputs
	output logic INT_CLK,
	output logic CPU_CLK_MIRROR,
	output logic SYSTEM_CLOCK_OUTPUT_H,
	output logic SYSTEM_CLOCK_OUTPUT_L,
	output logic DELAYED_SYSTEM_CLOCK,
	// AXI4-Lite write
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	localparam int SW_BOUND = 300;

	typedef struct packed {
		logic osc_lvl;
		logic osc_prv;
		logic ref_prv;
		logic on_ring;
		logic int_clk;
		logic slip;
		logic [2:0] lock_cnt;
		logic locked;
		logic [3:0] cnt;
		logic sys;
		logic [6:0] hist;
		logic mirror;
		logic sys_h;
		logic sys_l;
		logic dly_out;
		logic ref_mode;
		logic [3:0] div;
		logic [2:0] dly;
		logic aw_have;
		logic [3:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} cgc_state_t;

	cgc_state_t st, nxt;
	logic ring_lvl;
	logic ring_rise;
	logic absent;
	logic osc_chg;
	logic osc_rise;
	logic want_ring;
	logic tick;
	logic int_rise;
	logic ref_rise;
	logic out_scheme;
	logic [3:0] eff_div;
	logic [2:0] eff_dly;

	// ****************************************
	// Ring oscillator and absence detector
	// ****************************************
	cgc_ring #(.HALF_CYC(HALF_CYC)) u_ring (
		.clk(CLOCK),
		.rst_n(RSTN),
		.lvl(ring_lvl),
		.rise(ring_rise)
	);

	assign osc_chg = st.osc_lvl ^ st.osc_prv;

	cgc_absence #(.ABS_CYC(ABS_CYC)) u_absence (
		.clk(CLOCK),
		.rst_n(RSTN),
		.osc_edge(osc_chg),
		.absent(absent)
	);

	// ****************************************
	// Clock generation
	// ****************************************
	always_comb begin
		nxt = st;
		// Differential pair only counts as a new level when its two legs differ
		nxt.osc_lvl = (OSC_IN_H != OSC_IN_L) ? OSC_IN_H : st.osc_lvl;
		nxt.osc_prv = st.osc_lvl;
		nxt.ref_prv = REF_CLK_IN;
		osc_rise = st.osc_lvl & ~st.osc_prv;
		want_ring = !SUPPLY_GOOD || absent;
		// A dead oscillator caught mid-high phase is finished by the ring
		tick = st.on_ring ? ring_rise : (osc_rise || (absent && ring_rise));
		// Source changes only while the internal clock is low and idle
		if (!st.int_clk && !tick) begin
			nxt.on_ring = want_ring;
		end
		int_rise = tick && !st.int_clk && !st.slip;
		if (tick) begin
			if (!st.int_clk && st.slip) begin
				nxt.slip = 1'b0;
			end else begin
				nxt.int_clk = ~st.int_clk;
			end
		end
		nxt.mirror = st.on_ring ? ring_lvl : st.osc_lvl;
		// A divisor below two would park the system clock, so it is raised to two
		eff_div = st.on_ring ? RING_DIVISOR : ((st.div < DIV_MIN) ? DIV_MIN : st.div);
		eff_dly = st.on_ring ? RING_DELAY : st.dly;
		if (int_rise) begin
			nxt.cnt = (st.cnt >= eff_div - 4'h1) ? 4'h0 : st.cnt + 4'h1;
			nxt.sys = nxt.cnt < (eff_div >> 1);
			nxt.hist = {st.hist[5:0], st.sys};
		end
		// The ring keeps driving outputs even in reference mode
		out_scheme = !st.ref_mode || st.on_ring;
		nxt.sys_h = out_scheme & st.sys;
		nxt.sys_l = ~(out_scheme & st.sys);
		nxt.dly_out = out_scheme & ((eff_dly == 3'h0) ? st.sys : st.hist[eff_dly - 3'h1]);
		// Phase lock: every rising reference edge must meet ratio count zero
		ref_rise = REF_CLK_IN & ~st.ref_prv;
		if (!st.ref_mode || st.on_ring) begin
			nxt.slip = 1'b0;
			nxt.lock_cnt = 3'h0;
			nxt.locked = 1'b0;
		end else if (ref_rise) begin
			if (st.cnt != 4'h0) begin
				nxt.slip = 1'b1;
				nxt.lock_cnt = 3'h0;
				nxt.locked = 1'b0;
			end else begin
				nxt.lock_cnt = (st.lock_cnt == LOCK_COUNT) ? st.lock_cnt : st.lock_cnt + 3'h1;
				nxt.locked = (nxt.lock_cnt == LOCK_COUNT);
			end
		end

		// ****************************************
		// AXI4-Lite slave
		// ****************************************
		if (S_AXI_AWVALID && st.awready) begin
			nxt.aw_have = 1'b1;
			nxt.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st.wready) begin
			nxt.w_have = 1'b1;
			nxt.wdata = S_AXI_WDATA;
			nxt.wstrb = S_AXI_WSTRB;
		end
		if (S_AXI_BREADY && st.bvalid) begin
			nxt.bvalid = 1'b0;
		end
		if (st.aw_have && st.w_have && !st.bvalid) begin
			nxt.aw_have = 1'b0;
			nxt.w_have = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = RESP_OKAY;
			if (st.awaddr[3:2] == OFS_CTRL[3:2]) begin
				if (st.wstrb[0]) begin
					nxt.ref_mode = st.wdata[CTRL_MODE_BIT];
					nxt.div = st.wdata[CTRL_DIV_LSB +: 4];
				end
				if (st.wstrb[1]) begin
					nxt.dly = st.wdata[CTRL_DLY_LSB +: 3];
				end
			end else if (st.awaddr[3:2] != OFS_STATUS[3:2]) begin
				nxt.bresp = RESP_SLVERR;
			end
		end
		nxt.awready = !nxt.aw_have && !nxt.bvalid;
		nxt.wready = !nxt.w_have && !nxt.bvalid;
		if (S_AXI_RREADY && st.rvalid) begin
			nxt.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && st.arready) begin
			nxt.rvalid = 1'b1;
			nxt.rresp = RESP_OKAY;
			nxt.rdata = 32'h00000000;
			case (S_AXI_ARADDR[3:2])
				OFS_CTRL[3:2]: begin
					nxt.rdata[CTRL_MODE_BIT] = st.ref_mode;
					nxt.rdata[CTRL_DIV_LSB +: 4] = st.div;
					nxt.rdata[CTRL_DLY_LSB +: 3] = st.dly;
				end
				OFS_STATUS[3:2]: begin
					nxt.rdata[ST_RING_BIT] = st.on_ring;
					nxt.rdata[ST_ABSENT_BIT] = absent;
					nxt.rdata[ST_LOCK_BIT] = st.locked;
					nxt.rdata[ST_SUPPLY_BIT] = SUPPLY_GOOD;
				end
				default: begin
					nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		nxt.arready = !nxt.rvalid;
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			st <= '0;
			st.sys_l <= 1'b1;
			st.ref_prv <= 1'b1;
			st.ref_mode <= MODE_RST;
			st.div <= DIV_RST;
			st.dly <= DLY_RST;
		end else begin
			st <= nxt;
		end
	end

	assign INT_CLK = st.int_clk;
	assign CPU_CLK_MIRROR = st.mirror;
	assign SYSTEM_CLOCK_OUTPUT_H = st.sys_h;
	assign SYSTEM_CLOCK_OUTPUT_L = st.sys_l;
	assign DELAYED_SYSTEM_CLOCK = st.dly_out;
	assign S_AXI_AWREADY = st.awready;
	assign S_AXI_WREADY = st.wready;
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_BRESP = st.bresp;
	assign S_AXI_ARREADY = st.arready;
	assign S_AXI_RVALID = st.rvalid;
	assign S_AXI_RRESP = st.rresp;
	assign S_AXI_RDATA = st.rdata;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	chk_int_halving: assert property ($changed(st.int_clk) |-> $past(tick))
		else $error("internal clock moved without a source tick");
	chk_mirror_follow: assert property (
		(!st.on_ring && $past(!st.on_ring)) |-> st.mirror == $past(st.osc_lvl))
		else $error("mirror does not follow the oscillator");
	chk_sys_diff: assert property (st.sys_h != st.sys_l)
		else $error("system clock pair not complementary");
	chk_sys_ratio: assert property (
		$changed(st.sys) |-> $past(int_rise))
		else $error("system clock moved off an internal rising edge");
	chk_lock_slip: assert property (
		(st.ref_mode && !st.on_ring && ref_rise && st.cnt != 4'h0) |=> st.slip)
		else $error("misaligned reference edge did not request a slip");
	chk_supply_ring: assert property (
		(!SUPPLY_GOOD)[*8] |-> ##[0:SW_BOUND] (st.on_ring || SUPPLY_GOOD))
		else $error("supply good low but ring not selected");
	chk_ring_forced: assert property (st.on_ring |-> eff_div == 4'h8 && eff_dly == 3'h3)
		else $error("ring overrides not applied");
	chk_absent_ring: assert property (
		absent[*8] |-> ##[0:SW_BOUND] (st.on_ring || !absent))
		else $error("absent oscillator but ring not selected");
	chk_ring_cause: assert property ($rose(st.on_ring) |-> $past(!SUPPLY_GOOD || absent))
		else $error("ring selected without cause");
	chk_no_runt: assert property ($changed(st.on_ring) |-> !st.int_clk && !$past(st.int_clk))
		else $error("source switched while internal clock high");
	chk_lock_clear: assert property (
		(st.ref_mode && !st.on_ring && ref_rise && st.cnt != 4'h0) |=> !st.locked)
		else $error("misaligned reference edge left the lock flag set");
	// Parked pins in the reference scheme leave the chipset the only clock source
	chk_ref_quiet: assert property (
		(st.ref_mode && !st.on_ring) |=> !st.sys_h && st.sys_l && !st.dly_out)
		else $error("system clock driven in reference scheme");

	cov_to_ring: cover property ($rose(st.on_ring));
	cov_back_osc: cover property ($fell(st.on_ring));
	cov_locked: cover property ($rose(st.locked));
	cov_sys_rise: cover property ($rose(st.sys_h) && !st.on_ring);
	cov_slip: cover property ($rose(st.slip));
endmodule // cgc_top

// [inc/cgc_pkg.sv]
/*
 Constants for the clock generation and selection block: register map,
 field positions, reset values, forced ring settings and timing counts.
 Assumes a single 100 MHz register clock.

*/
package cgc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ABSENT_TIME_NS = 200;
	localparam int unsigned ABSENT_CYC = (ABSENT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RING_HALF_NS = 30;
	localparam int unsigned RING_HALF_CYC = (RING_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] LOCK_COUNT = 3'h4;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_DIV_LSB = 4;
	localparam int CTRL_DLY_LSB = 8;
	localparam int ST_RING_BIT = 0;
	localparam int ST_ABSENT_BIT = 1;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_SUPPLY_BIT = 3;
	localparam logic MODE_RST = 1'b0;
	localparam logic [3:0] DIV_RST = 4'h4;
	localparam logic [2:0] DLY_RST = 3'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Ring oscillator overrides and oscillator divisor floor
	// ****************************************
	localparam logic [3:0] RING_DIVISOR = 4'h8;
	localparam logic [2:0] RING_DELAY = 3'h3;
	localparam logic [3:0] DIV_MIN = 4'h2;

endpackage

// [sim/cgc_partner.sv]
/*
 Board oscillator and chipset reference clock model.
 Assumes CLOCK paces both; levels change just after its rising edge.
*/
`timescale 1ns/1ps
module cgc_partner #(
	parameter int OSC_HALF = 3,
	parameter int REF_HALF = 24
) (
	// Clock
	input wire logic clk,
	// Bench controls
	input wire logic osc_run,
	input wire logic ref_run,
	// Pins
	output logic osc_h,
	output logic osc_l,
	output logic ref_clk
);
	int oc = 0;
	int rc = 0;
	initial begin
		osc_h = 1'h0;
		ref_clk = 1'h1;
	end
	assign osc_l = ~osc_h;
	// A stopped oscillator holds its level: no edges reach the detector
	always @(posedge clk) begin
		oc <= (oc + 1) % OSC_HALF;
		if (osc_run && oc == OSC_HALF - 1) begin
			osc_h <= ~osc_h;
		end
	end
	always @(posedge clk) begin
		rc <= (rc + 1) % REF_HALF;
		if (!ref_run) begin
			ref_clk <= 1'h1;
		end else if (rc == REF_HALF - 1) begin
			ref_clk <= ~ref_clk;
		end
	end
endmodule // cgc_partner

// [sim/cgc_top_tb.sv]
/*
 Self-checking bench: AXI4-Lite register access, clock periods measured
 in CLOCK cycles. Assumes cgc_pkg and cgc_partner are compiled first.
*/
`timescale 1ns/1ps
module cgc_top_tb import cgc_pkg::*;;
	localparam int OH = 3;
	localparam int HC = 2;
	localparam int IP = 4 * OH;
	localparam int RP = 4 * HC;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic supply_good = 1'h1;
	logic osc_run = 1'h1;
	logic ref_run = 1'h0;
	wire logic osc_h, osc_l, ref_clk;
	logic int_clk, mirror, sys_h, sys_l, dly_clk;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int miscompares = 0;
	int tests_run = 0;
	int run_len = 0;
	int min_run = 1000;
	logic seen = 1'h0;
	logic last = 1'h0;
	logic [1:0] osc_d = 2'h0;

	always #5 clk = ~clk;

	cgc_partner #(.OSC_HALF(OH), .REF_HALF(2 * IP)) u_cgc_partner (.clk(clk),
		.osc_run(osc_run), .ref_run(ref_run), .osc_h(osc_h), .osc_l(osc_l), .ref_clk(ref_clk));
	cgc_top #(.ABS_CYC(8), .HALF_CYC(HC)) u_cgc_top (.CLOCK(clk), .RSTN(rst_n),
		.OSC_IN_H(osc_h), .OSC_IN_L(osc_l), .SUPPLY_GOOD(supply_good), .REF_CLK_IN(ref_clk),
		.INT_CLK(int_clk), .CPU_CLK_MIRROR(mirror), .SYSTEM_CLOCK_OUTPUT_H(sys_h),
		.SYSTEM_CLOCK_OUTPUT_L(sys_l), .DELAYED_SYSTEM_CLOCK(dly_clk),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	// Shortest internal clock phase, counted from the first toggle after reset
	always @(negedge clk) begin
		last <= int_clk;
		run_len <= (int_clk !== last) ? 1 : run_len + 1;
		if (int_clk !== last && seen && run_len < min_run) min_run <= run_len;
		if (int_clk !== last) seen <= rst_n;
	end
	always @(posedge clk) osc_d <= {osc_d[0], osc_h};

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (awvalid && !awready || wvalid && !wready);
		while (!bvalid) @(posedge clk);
		bready <= 1'h0;
		chk("bresp", er, bresp);
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask
	task automatic st(input string n, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(n, e, d & m);
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? int_clk : s == 1 ? sys_h : dly_clk;
	endfunction
	// Period and high time of a clock output, from one rise to the next
	task automatic chk_clk(input string n, input int s, input int per, input int hi);
		int p;
		int h;
		h = 0;
		while (pick(s) !== 1'h0) @(negedge clk);
		while (pick(s) !== 1'h1) @(negedge clk);
		while (pick(s) === 1'h1) begin
			@(negedge clk);
			h++;
		end
		p = h;
		while (pick(s) === 1'h0) begin
			@(negedge clk);
			p++;
		end
		chk(n, per, p);
		chk(n, hi, h);
	endtask
	// Lag of the delayed clock behind the system clock, in internal periods
	task automatic chk_dly(input string n, input int e, input int per);
		int c;
		c = 0;
		while (sys_h !== 1'h0) @(negedge clk);
		while (sys_h !== 1'h1) @(negedge clk);
		while (dly_clk !== 1'h1) begin
			@(negedge clk);
			c++;
		end
		chk(n, e, (c + per / 2) / per);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int bad;
		int dv[4] = '{2, 3, 6, 4};
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		st("ctrl reset", OFS_CTRL, 32'h7F1, {21'h0, DLY_RST, DIV_RST, 3'h0, MODE_RST});
		axi_rd(4'h8, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", RESP_SLVERR, r);
		axi_wr(4'hC, 32'h0, 4'hF, RESP_SLVERR);
		axi_wr(OFS_STATUS, 32'hF, 4'hF, RESP_OKAY);
		repeat (40) @(posedge clk);
		st("status osc", OFS_STATUS, 32'hB, 32'h8);
		chk_clk("int osc", 0, IP, IP / 2);
		bad = 0;
		repeat (4 * IP) begin
			@(negedge clk);
			if (mirror !== osc_d[1]) bad++;
		end
		chk("mirror", 0, bad);
		foreach (dv[i]) begin
			axi_wr(OFS_CTRL, dv[i] << 4, 4'h1, RESP_OKAY);
			repeat (12 * IP) @(posedge clk);
			chk_clk("sys div", 1, dv[i] * IP, dv[i] / 2 * IP);
			chk("sys pair", 1, sys_h ^ sys_l);
		end
		axi_wr(OFS_CTRL, 32'h2F1, 4'h2, RESP_OKAY);
		st("ctrl strobe", OFS_CTRL, 32'h7F1, 32'h240);
		supply_good <= 1'h0;
		repeat (100) @(posedge clk);
		st("status ring", OFS_STATUS, 32'h9, 32'h1);
		chk_clk("int ring", 0, RP, RP / 2);
		chk_clk("sys ring", 1, 8 * RP, 4 * RP);
		chk_dly("delay ring", 3, RP);
		supply_good <= 1'h1;
		repeat (100) @(posedge clk);
		st("status back", OFS_STATUS, 32'h3, 32'h0);
		chk_dly("delay osc", 2, IP);
		osc_run <= 1'h0;
		repeat (100) @(posedge clk);
		st("status absent", OFS_STATUS, 32'hB, 32'hB);
		chk_clk("int absent", 0, RP, RP / 2);
		osc_run <= 1'h1;
		repeat (100) @(posedge clk);
		st("status edges", OFS_STATUS, 32'h3, 32'h0);
		axi_wr(OFS_CTRL, 32'h41, 4'h1, RESP_OKAY);
		ref_run <= 1'h1;
		repeat (800) @(posedge clk);
		st("status lock", OFS_STATUS, 32'h7, 32'h4);
		chk_clk("int ref", 0, IP, IP / 2);
		chk("sys held", 32'h1, {sys_h, sys_l});
		chk("min phase", 1, min_run >= 2 * HC);
		report_and_stop();
	end
	// Tests take a few thousand cycles; this span is several times that
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule // cgc_top_tb
